// ### pkg/tecdrv_pkg.sv
// Constants, field layout and types shared by the cooler-driver register bank.
`default_nettype none
package tecdrv_pkg;
	localparam int CLK_KHZ = 25000;
	localparam int DIS_SHORT_MS = 30;
	localparam int SS_SHORTEST_MS = 15;

	localparam int REG_W = 8;
	localparam int BUS_ADDR_W = 7;
	localparam int CODE_W = 6;
	localparam int NFLAGS = 4;

	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_HEAT_CAP = 8'h01;
	localparam logic [7:0] OFF_COOL_CAP = 8'h02;

	localparam logic [7:0] RST_CTRL = 8'h91;
	localparam logic [7:0] RST_CURRENT_CAP = 8'hA6;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	localparam int CTRL_MON_BIT = 7;
	localparam int CTRL_DIS_BIT = 4;
	localparam int CTRL_SS_LSB = 2;
	localparam int CTRL_REFRESH_BIT = 1;
	localparam int CTRL_PWR_BIT = 0;
	localparam int CAP_EN_BIT = 7;
	localparam logic [1:0] SS_LONGEST_SHIFT = 2'h3;

	localparam logic [6:0] ADDR_STRAP_LOW = 7'h21;
	localparam logic [6:0] ADDR_STRAP_FLOAT = 7'h60;

	localparam logic [11:0] CURRENT_STEP_MA = 12'h027;
	localparam logic [5:0] CURRENT_MAX_CODE = 6'h34;
	localparam logic [11:0] CURRENT_MAX_MA = 12'h7EC;
	localparam logic [15:0] VOLTAGE_STEP_DMV = 16'h03D0;
	localparam logic [5:0] VOLTAGE_MAX_CODE = 6'h39;

	localparam int FLAG_VOLT = 0;
	localparam int FLAG_CURR = 1;
	localparam int FLAG_OT = 2;
	localparam int FLAG_OTW = 3;

	typedef enum logic [1:0] {
		MODE_BOUNDARY = 2'h0,
		MODE_COOL     = 2'h1,
		MODE_HEAT     = 2'h2,
		MODE_RESERVED = 2'h3
	} tecdrv_mode_e;
endpackage : tecdrv_pkg
`default_nettype wire

// ### pkg/tecdrv_flag_if.sv
// Carrier between the register bank and its sticky status flags.
`default_nettype none
interface tecdrv_flag_if #(parameter int N = 4);
	logic [N-1:0] set;
	logic         release_all;
	logic [N-1:0] flags;
	modport bank  (output set, output release_all, input flags);
	modport latch (input set, input release_all, output flags);
endinterface : tecdrv_flag_if
`default_nettype wire

// ### hw/tecdrv_status_latch.sv
// Sticky status flags released only on request.
`default_nettype none
module tecdrv_status_latch #(
	parameter int N = 4
) (
	input  wire logic     clk_i,
	input  wire logic     rst_b_i,
	input  wire logic     en_i,
	tecdrv_flag_if.latch  fl
);
	if (N < 1) begin : g_chk
		$error("Flag count must be at least one.");
	end

	logic [N-1:0] flags_q;
	logic [N-1:0] flags_d;

	// A condition present in the release cycle survives it.
	always_comb begin
		flags_d = flags_q;
		if (en_i) begin
			flags_d = (fl.release_all ? '0 : flags_q) | fl.set; // [RULE15]
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flags_q <= '0;
		end else begin
			flags_q <= flags_d;
		end
	end

	assign fl.flags = flags_q;
endmodule : tecdrv_status_latch
`default_nettype wire

// ### hw/tecdrv_regs.sv
// Configuration register bank of the cooler driver with its setting outputs.
// Notes on behaviour
// RULE1 - Every register is eight bits, bit 0 least significant.
// RULE2 - Multi-bit fields are unsigned binary codes.
// RULE3 - Bus address 0x21 with strap low, 0x60 when floating.
// RULE4 - Control bit 7 picks monitor: voltage at 0, current at 1; resets 1.
// RULE5 - Control bit 4 picks discharge: 60 ms at 0, 30 ms at 1; resets 1.
// RULE6 - Control bits 3:2 pick soft start 120, 60, 30 or 15 ms.
// RULE7 - Writing 1 to control bit 1 releases flags, then clears itself.
// RULE8 - Control bit 0 enables the power stage; resets 1.
// RULE9 - Heating cap register bit 7 enables heating current capping.
// RULE10 - Heating cap bits 5:0 hold the code, reset 100110; bit 6 reserved.
// RULE11 - Cooling cap register bit 7 enables cooling current capping.
// RULE12 - Cooling cap bits 5:0 hold the code, reset 100110; bit 6 reserved.
// RULE13 - Current code maps to 39 mA per step, 2028 mA at most.
// RULE14 - Voltage code maps to 97.6 mV per step, 5563.2 mV at most.
// RULE15 - Limit and temperature flags latch until a release is requested.
// RULE16 - Mode 01 cooling, 10 heating; matching limits apply per mode.
// RULE17 - A host write reaches the setting outputs on the next cycle; the discharge and soft-start counts and the caps arrive one cycle after that.
// RULE18 - The host avoids reserved limit codes.
`default_nettype none
module tecdrv_regs #(
	parameter int DUR_W = 24,
	parameter int DIS_MIN_CYC = tecdrv_pkg::DIS_SHORT_MS * tecdrv_pkg::CLK_KHZ,
	parameter int SS_MIN_CYC = tecdrv_pkg::SS_SHORTEST_MS * tecdrv_pkg::CLK_KHZ
) (
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	input  wire logic        en_i,
	input  wire logic        addr_strap_low_i,
	input  wire logic [6:0]  bus_addr_i,
	input  wire logic        bus_wr_i,
	input  wire logic        bus_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic [1:0]  mode_i,
	input  wire logic [5:0]  heat_voltage_cap_code_i,
	input  wire logic [5:0]  cool_voltage_cap_code_i,
	input  wire logic [3:0]  status_event_i,
	output logic [7:0]       rdata_o,
	output logic             ack_o,
	output logic [6:0]       own_addr_o,
	output logic             monitor_output_select_o,
	output logic             discharge_duration_sel_o,
	output logic [DUR_W-1:0] discharge_cycles_o,
	output logic [DUR_W-1:0] soft_start_cycles_o,
	output logic             power_stage_en_o,
	output logic [1:0]       mode_o,
	output logic             current_cap_en_o,
	output logic [11:0]      current_cap_ma_o,
	output logic [15:0]      voltage_cap_dmv_o,
	output logic [3:0]       status_latched_o
);
	if (DUR_W < 2 || DUR_W > 31 || DIS_MIN_CYC < 1 || SS_MIN_CYC < 1
		|| longint'(SS_MIN_CYC) * 8 >= (longint'(1) << DUR_W)
		|| longint'(DIS_MIN_CYC) * 2 >= (longint'(1) << DUR_W)) begin : g_chk
		$error("Duration counts do not fit DUR_W.");
	end

	logic       rst_m_q, rst_q;
	logic       strap_done_q, strap_done_d;
	logic [6:0] own_addr_q, own_addr_d;
	logic [7:0] ctrl_q, ctrl_d, heat_q, heat_d, cool_q, cool_d;
	logic [7:0] rdata_q, rdata_d;
	logic       ack_q, ack_d;
	logic       hit, wr_hit, rd_hit;
	logic       dis_sel_q, dis_sel_d, mon_q, mon_d, pwr_q, pwr_d;
	logic [DUR_W-1:0] dis_cyc_q, dis_cyc_d, ss_cyc_q, ss_cyc_d;
	logic [1:0]  mode_q, mode_d;
	logic        cap_en_q, cap_en_d;
	logic [11:0] cap_ma_q, cap_ma_d;
	logic [15:0] vcap_q, vcap_d;
	logic [5:0]  icode, vcode;

	// Reset is released through two flops so every flop reset by rst_q leaves reset together.
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_m_q <= 1'b0;
			rst_q   <= 1'b0;
		end else begin
			rst_m_q <= 1'b1;
			rst_q   <= rst_m_q;
		end
	end

	tecdrv_flag_if #(.N(tecdrv_pkg::NFLAGS)) flag_bus ();

	tecdrv_status_latch #(.N(tecdrv_pkg::NFLAGS)) u_flags (
		.clk_i   (clk_i),
		.rst_b_i (rst_q),
		.en_i    (en_i),
		.fl      (flag_bus.latch)
	);

	assign flag_bus.set         = status_event_i;
	assign flag_bus.release_all = ctrl_q[tecdrv_pkg::CTRL_REFRESH_BIT]; // [RULE7]

	// The strap is sampled once after reset, never under the async reset.
	assign hit    = strap_done_q && (bus_addr_i == own_addr_q); // [RULE3]
	assign wr_hit = en_i && hit && bus_wr_i;
	assign rd_hit = en_i && hit && bus_rd_i && !bus_wr_i;

	always_comb begin
		strap_done_d = strap_done_q;
		own_addr_d   = own_addr_q;
		if (en_i && !strap_done_q) begin
			strap_done_d = 1'b1;
			own_addr_d   = addr_strap_low_i ? tecdrv_pkg::ADDR_STRAP_LOW
			                                : tecdrv_pkg::ADDR_STRAP_FLOAT; // [RULE3]
		end
	end

	// Register file: eight-bit words, all fields plain unsigned codes.
	always_comb begin
		ctrl_d  = ctrl_q;
		heat_d  = heat_q;
		cool_d  = cool_q;
		rdata_d = rdata_q;
		ack_d   = ack_q;
		if (en_i) begin
			ack_d = wr_hit || rd_hit;
			ctrl_d[tecdrv_pkg::CTRL_REFRESH_BIT] = 1'b0; // [RULE7]
			if (wr_hit) begin
				unique case (reg_addr_i)
					tecdrv_pkg::OFF_CTRL:     ctrl_d = wdata_i; // [RULE1] [RULE7]
					tecdrv_pkg::OFF_HEAT_CAP: heat_d = wdata_i; // [RULE9] [RULE10]
					tecdrv_pkg::OFF_COOL_CAP: cool_d = wdata_i; // [RULE11] [RULE12]
					default: ;
				endcase
			end
			if (rd_hit) begin
				unique case (reg_addr_i)
					tecdrv_pkg::OFF_CTRL:     rdata_d = ctrl_q;
					tecdrv_pkg::OFF_HEAT_CAP: rdata_d = heat_q;
					tecdrv_pkg::OFF_COOL_CAP: rdata_d = cool_q;
					default:                  rdata_d = tecdrv_pkg::RDATA_UNMAPPED;
				endcase
			end
		end
	end

	// Select and enable outputs follow a write one cycle later, counts and caps two cycles later, even while running.
	always_comb begin
		mon_d     = mon_q;
		dis_sel_d = dis_sel_q;
		pwr_d     = pwr_q;
		dis_cyc_d = dis_cyc_q;
		ss_cyc_d  = ss_cyc_q;
		mode_d    = mode_q;
		cap_en_d  = cap_en_q;
		cap_ma_d  = cap_ma_q;
		vcap_d    = vcap_q;
		icode     = '0;
		vcode     = '0;
		if (en_i) begin
			mon_d     = ctrl_d[tecdrv_pkg::CTRL_MON_BIT]; // [RULE4] [RULE17]
			dis_sel_d = ctrl_d[tecdrv_pkg::CTRL_DIS_BIT];
			pwr_d     = ctrl_d[tecdrv_pkg::CTRL_PWR_BIT]; // [RULE8] [RULE17]
			dis_cyc_d = ctrl_q[tecdrv_pkg::CTRL_DIS_BIT]
			            ? DUR_W'(DIS_MIN_CYC)
			            : DUR_W'(DIS_MIN_CYC * 2); // [RULE5]
			ss_cyc_d  = DUR_W'(SS_MIN_CYC) << (tecdrv_pkg::SS_LONGEST_SHIFT
			            - ctrl_q[tecdrv_pkg::CTRL_SS_LSB +: 2]); // [RULE6] [RULE2]
			// Boundary and reserved indications keep the last applied limits.
			if (mode_i == tecdrv_pkg::MODE_HEAT || mode_i == tecdrv_pkg::MODE_COOL) begin
				mode_d = mode_i; // [RULE16]
			end
			if (mode_q == tecdrv_pkg::MODE_HEAT) begin
				cap_en_d = heat_q[tecdrv_pkg::CAP_EN_BIT];
				icode    = heat_q[tecdrv_pkg::CODE_W-1:0];
				vcode    = heat_voltage_cap_code_i;
			end else begin
				cap_en_d = cool_q[tecdrv_pkg::CAP_EN_BIT];
				icode    = cool_q[tecdrv_pkg::CODE_W-1:0];
				vcode    = cool_voltage_cap_code_i;
			end // [RULE16]
			// Reserved codes saturate so a careless host cannot exceed the table.
			if (icode > tecdrv_pkg::CURRENT_MAX_CODE) begin
				icode = tecdrv_pkg::CURRENT_MAX_CODE;
			end
			if (vcode > tecdrv_pkg::VOLTAGE_MAX_CODE) begin
				vcode = tecdrv_pkg::VOLTAGE_MAX_CODE;
			end
			cap_ma_d = 12'({6'h00, icode} * tecdrv_pkg::CURRENT_STEP_MA); // [RULE13]
			vcap_d   = 16'({10'h000, vcode} * tecdrv_pkg::VOLTAGE_STEP_DMV); // [RULE14]
		end
	end

	always_ff @(posedge clk_i or negedge rst_q) begin
		if (!rst_q) begin
			strap_done_q <= 1'b0;
			own_addr_q   <= tecdrv_pkg::ADDR_STRAP_FLOAT;
			ctrl_q       <= tecdrv_pkg::RST_CTRL;
			heat_q       <= tecdrv_pkg::RST_CURRENT_CAP;
			cool_q       <= tecdrv_pkg::RST_CURRENT_CAP;
			rdata_q      <= tecdrv_pkg::RDATA_UNMAPPED;
			ack_q        <= 1'b0;
			mon_q        <= tecdrv_pkg::RST_CTRL[tecdrv_pkg::CTRL_MON_BIT];
			dis_sel_q    <= tecdrv_pkg::RST_CTRL[tecdrv_pkg::CTRL_DIS_BIT];
			pwr_q        <= tecdrv_pkg::RST_CTRL[tecdrv_pkg::CTRL_PWR_BIT];
			dis_cyc_q    <= DUR_W'(DIS_MIN_CYC);
			ss_cyc_q     <= DUR_W'(SS_MIN_CYC) << tecdrv_pkg::SS_LONGEST_SHIFT;
			mode_q       <= tecdrv_pkg::MODE_COOL;
			cap_en_q     <= tecdrv_pkg::RST_CURRENT_CAP[tecdrv_pkg::CAP_EN_BIT];
			cap_ma_q     <= '0;
			vcap_q       <= '0;
		end else begin
			strap_done_q <= strap_done_d;
			own_addr_q   <= own_addr_d;
			ctrl_q       <= ctrl_d;
			heat_q       <= heat_d;
			cool_q       <= cool_d;
			rdata_q      <= rdata_d;
			ack_q        <= ack_d;
			mon_q        <= mon_d;
			dis_sel_q    <= dis_sel_d;
			pwr_q        <= pwr_d;
			dis_cyc_q    <= dis_cyc_d;
			ss_cyc_q     <= ss_cyc_d;
			mode_q       <= mode_d;
			cap_en_q     <= cap_en_d;
			cap_ma_q     <= cap_ma_d;
			vcap_q       <= vcap_d;
		end
	end

	assign rdata_o                  = rdata_q;
	assign ack_o                    = ack_q;
	assign own_addr_o               = own_addr_q;
	assign monitor_output_select_o  = mon_q;
	assign discharge_duration_sel_o = dis_sel_q;
	assign discharge_cycles_o       = dis_cyc_q;
	assign soft_start_cycles_o      = ss_cyc_q;
	assign power_stage_en_o         = pwr_q;
	assign mode_o                   = mode_q;
	assign current_cap_en_o         = cap_en_q;
	assign current_cap_ma_o         = cap_ma_q;
	assign voltage_cap_dmv_o        = vcap_q;
	assign status_latched_o         = flag_bus.flags;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_q);

	AST_REFRESH_SELF_CLEARS: assert property ( // [RULE7]
		en_i && ctrl_q[tecdrv_pkg::CTRL_REFRESH_BIT]
		&& !(wr_hit && reg_addr_i == tecdrv_pkg::OFF_CTRL)
		|=> !ctrl_q[tecdrv_pkg::CTRL_REFRESH_BIT]
	) else $error("Release bit did not clear itself.");
	AST_RELEASE_EMPTIES_FLAGS: assert property ( // [RULE15]
		en_i && ctrl_q[tecdrv_pkg::CTRL_REFRESH_BIT] && status_event_i == '0
		|=> status_latched_o == '0
	) else $error("Status flags survived a release.");
	AST_FLAGS_STICKY: assert property ( // [RULE15]
		!ctrl_q[tecdrv_pkg::CTRL_REFRESH_BIT] |=> ($past(status_latched_o)
		& ~status_latched_o) == '0
	) else $error("A latched flag dropped without a release.");
	AST_EVENT_SETS_FLAG: assert property ( // [RULE15]
		en_i && status_event_i != '0
		|=> (status_latched_o & $past(status_event_i)) == $past(status_event_i)
	) else $error("A status event was not latched.");
	AST_PWR_FOLLOWS_WRITE: assert property ( // [RULE8]
		wr_hit && reg_addr_i == tecdrv_pkg::OFF_CTRL
		|=> power_stage_en_o == $past(wdata_i[tecdrv_pkg::CTRL_PWR_BIT])
	) else $error("Power stage enable did not follow the write.");
	AST_MON_FOLLOWS_WRITE: assert property ( // [RULE4] [RULE17]
		wr_hit && reg_addr_i == tecdrv_pkg::OFF_CTRL
		|=> monitor_output_select_o == $past(wdata_i[tecdrv_pkg::CTRL_MON_BIT])
	) else $error("Monitor select did not follow the write.");
	AST_DISCHARGE_TIME: assert property ( // [RULE5]
		wr_hit && reg_addr_i == tecdrv_pkg::OFF_CTRL ##1 en_i
		|=> discharge_cycles_o == ($past(wdata_i[tecdrv_pkg::CTRL_DIS_BIT], 2)
		    ? DUR_W'(DIS_MIN_CYC) : DUR_W'(DIS_MIN_CYC * 2))
	) else $error("Discharge duration wrong for the selected code.");
	AST_SOFT_START_SHORTEST: assert property ( // [RULE6]
		en_i && ctrl_q[tecdrv_pkg::CTRL_SS_LSB +: 2] == 2'h3
		|=> soft_start_cycles_o == DUR_W'(SS_MIN_CYC)
	) else $error("Shortest soft start count wrong.");
	AST_CURRENT_CAP_RANGE: assert property ( // [RULE13]
		current_cap_ma_o <= tecdrv_pkg::CURRENT_MAX_MA
	) else $error("Current cap above the table maximum.");
	AST_FOREIGN_ADDR_IGNORED: assert property ( // [RULE3]
		en_i && bus_addr_i != own_addr_q |=> !ack_o
	) else $error("Answered on a foreign bus address.");

	COV_RELEASE: cover property (
		ctrl_q[tecdrv_pkg::CTRL_REFRESH_BIT] && status_latched_o != '0);
	COV_HEAT_MODE: cover property (
		mode_q == tecdrv_pkg::MODE_COOL ##1 mode_q == tecdrv_pkg::MODE_HEAT);
	COV_READ_BACK: cover property (rd_hit ##1 ack_o);
endmodule : tecdrv_regs
`default_nettype wire

// ### dv/tecdrv_host.sv
// Behavioural host that issues single-byte register accesses to the bank.
`default_nettype none
module tecdrv_host (
	input  wire logic       clk_i,
	input  wire logic [6:0] dev_addr_i,
	input  wire logic       ack_i,
	input  wire logic [7:0] rdata_i,
	output logic [6:0]      bus_addr_o,
	output logic            bus_wr_o,
	output logic            bus_rd_o,
	output logic [7:0]      reg_addr_o,
	output logic [7:0]      wdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		bus_addr_o = 7'h00;
		bus_wr_o = 1'b0;
		bus_rd_o = 1'b0;
		reg_addr_o = 8'hFF;
		wdata_o = 8'hFF;
	end
	// Limit codes go out as given, so callers keep them inside the table.
	// After the strobe the address and data lines show inverted values and both strobes drop, never stale ones.
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic ok);
		@(posedge clk_i);
		bus_addr_o <= dev_addr_i;
		bus_wr_o <= w;
		bus_rd_o <= !w;
		reg_addr_o <= a;
		wdata_o <= d;
		@(posedge clk_i);
		bus_addr_o <= ~dev_addr_i;
		bus_wr_o <= 1'b0;
		bus_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		wdata_o <= ~d;
		@(posedge clk_i);
		ok = ack_i;
		q = rdata_i;
	endtask : xfer
endmodule : tecdrv_host
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the cooler-driver register bank.
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
	miscompares++; $display("BAD t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int DIS = 4;
	localparam int SS = 2;
	logic        clk, rst_b, en, strap, wr, rd, ack, mon, dsel, pwr, cen;
	logic [6:0]  baddr, dev, own;
	logic [7:0]  raddr, wdata, rdata, q;
	logic [1:0]  mode, mo;
	logic [5:0]  hv, cv;
	logic [3:0]  ev, st;
	logic [23:0] dcyc, sscyc;
	logic [11:0] ma;
	logic [15:0] dmv;
	logic        ok;
	int          miscompares = 0;
	int          total_checks = 0;
	tecdrv_regs #(.DUR_W(24), .DIS_MIN_CYC(DIS), .SS_MIN_CYC(SS)) u_tecdrv_regs (
		.clk_i(clk), .rst_b_i(rst_b), .en_i(en), .addr_strap_low_i(strap),
		.bus_addr_i(baddr), .bus_wr_i(wr), .bus_rd_i(rd), .reg_addr_i(raddr),
		.wdata_i(wdata), .mode_i(mode), .heat_voltage_cap_code_i(hv),
		.cool_voltage_cap_code_i(cv), .status_event_i(ev), .rdata_o(rdata),
		.ack_o(ack), .own_addr_o(own), .monitor_output_select_o(mon),
		.discharge_duration_sel_o(dsel), .discharge_cycles_o(dcyc),
		.soft_start_cycles_o(sscyc), .power_stage_en_o(pwr), .mode_o(mo),
		.current_cap_en_o(cen), .current_cap_ma_o(ma),
		.voltage_cap_dmv_o(dmv), .status_latched_o(st));
	tecdrv_host u_tecdrv_host (.clk_i(clk), .dev_addr_i(dev), .ack_i(ack),
		.rdata_i(rdata), .bus_addr_o(baddr), .bus_wr_o(wr), .bus_rd_o(rd),
		.reg_addr_o(raddr), .wdata_o(wdata));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic apply_reset();
		tick(1);
		rst_b <= 1'b0;
		tick(4);
		rst_b <= 1'b1;
		tick(4);
	endtask : apply_reset
	task automatic do_wr(input logic [7:0] a, input logic [7:0] d);
		u_tecdrv_host.xfer(1'b1, a, d, q, ok);
		`CHK(ok, 1'b1)
	endtask : do_wr
	task automatic do_rd(input logic [7:0] a, input logic [7:0] e);
		u_tecdrv_host.xfer(1'b0, a, 8'h00, q, ok);
		`CHK(ok, 1'b1)
		`CHK(q, e)
	endtask : do_rd
	task automatic t_reset();
		do_rd(8'h00, 8'h91);
		do_rd(8'h01, 8'hA6);
		do_rd(8'h02, 8'hA6);
		`CHK(mon, 1'b1)
		`CHK(dsel, 1'b1)
		`CHK(dcyc, 24'(DIS))
		`CHK(sscyc, 24'(8 * SS))
		`CHK(pwr, 1'b1)
		`CHK(cen, 1'b1)
		`CHK(ma, 12'h5CA)
		`CHK(own, 7'h21)
		$display("test reset done");
	endtask : t_reset
	task automatic t_ctrl();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = 8'h60 | 8'(i << 2);
			do_wr(8'h00, v);
			tick(1);
			`CHK(sscyc, 24'(SS << (3 - i)))
			`CHK(dcyc, 24'(2 * DIS))
			`CHK(dsel, 1'b0)
			`CHK(mon, 1'b0)
			`CHK(pwr, 1'b0)
			do_rd(8'h00, v);
		end
		do_wr(8'h00, 8'h91);
		$display("test control done");
	endtask : t_ctrl
	task automatic t_caps();
		mode <= 2'h1;
		cv <= 6'h39;
		do_wr(8'h02, 8'hB4);
		tick(2);
		`CHK(cen, 1'b1)
		`CHK(ma, 12'h7EC)
		`CHK(dmv, 16'hD950)
		mode <= 2'h2;
		hv <= 6'h1C;
		do_wr(8'h01, 8'h41);
		tick(2);
		`CHK(mo, 2'h2)
		`CHK(cen, 1'b0)
		`CHK(ma, 12'h027)
		`CHK(dmv, 16'h6AC0)
		mode <= 2'h0;
		tick(3);
		`CHK(mo, 2'h2)
		mode <= 2'h3;
		tick(3);
		`CHK(mo, 2'h2)
		do_rd(8'h01, 8'h41);
		do_rd(8'h02, 8'hB4);
		$display("test caps done");
	endtask : t_caps
	task automatic t_flags();
		ev <= 4'h5;
		tick(1);
		ev <= 4'h0;
		tick(3);
		`CHK(st, 4'h5)
		do_wr(8'h00, 8'h93);
		tick(2);
		`CHK(st, 4'h0)
		do_rd(8'h00, 8'h91);
		ev <= 4'hA;
		tick(1);
		ev <= 4'h0;
		tick(3);
		`CHK(st, 4'hA)
		// An event standing through the release must survive it.
		ev <= 4'h2;
		do_wr(8'h00, 8'h93);
		ev <= 4'h0;
		tick(2);
		`CHK(st, 4'h2)
		$display("test flags done");
	endtask : t_flags
	task automatic t_addr();
		dev <= 7'h60;
		u_tecdrv_host.xfer(1'b1, 8'h00, 8'h00, q, ok);
		`CHK(ok, 1'b0)
		dev <= 7'h21;
		en <= 1'b0;
		u_tecdrv_host.xfer(1'b1, 8'h00, 8'h00, q, ok);
		`CHK(ok, 1'b0)
		en <= 1'b1;
		do_rd(8'h00, 8'h91);
		do_wr(8'h07, 8'h55);
		do_rd(8'h07, 8'h00);
		strap <= 1'b0;
		apply_reset();
		`CHK(own, 7'h60)
		dev <= 7'h60;
		do_rd(8'h01, 8'hA6);
		$display("test address done");
	endtask : t_addr
	task automatic finish_test();
		$display("checks=%0d mismatches=%0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : finish_test
	initial begin
		rst_b = 1'b0;
		en = 1'b1;
		strap = 1'b1;
		dev = 7'h21;
		mode = 2'h1;
		hv = 6'h00;
		cv = 6'h00;
		ev = 4'h0;
		apply_reset();
		t_reset();
		t_ctrl();
		t_caps();
		t_flags();
		t_addr();
		finish_test();
	end
	// The tests take well under a thousand cycles; this cuts off a hang.
	initial begin
		repeat (20000) @(posedge clk);
		miscompares++;
		finish_test();
	end
endmodule : tb
`default_nettype wire
